// *** reg_init_bank.sv ***
// peripheral register bank with reset-class initialization and wake-up vectoring
// assumes event strobes are synchronous to clk and arrive one at a time
//
// Operation
// - interrupt wake with global enable pushes pc to stack top, bumps pointer
// - interrupt wake with global enable loads pc with 0008h or 0018h
// - interrupt wake leaves a cause flag (wake_cause) set in request1 only, request3 unchanged
// - unimplemented bits read zero and ignore writes
// - capture/compare controls clear on both reset classes, kept on wake
// - comparator control loads 0000 0111 on resets, kept on wake
// - timer3 control clears only on power-on or brown-out
// - usart transmit status resets to 0000 0010, kept on wake
// - usart receive status clears upper seven bits, bit 0 undefined
// - timer4 period forced all ones on resets and on wake
// - peripheral priority registers reset to all ones, kept on wake
// - peripheral enable registers clear on resets, kept on wake
// - capture/compare data undefined at power-on, otherwise retained
// - timer3 count undefined at power-on, otherwise retained
// - timer4 counter and seven control bits clear on resets, kept on wake
// - flash control clears three bits always, error flag undefined at power-on
// - pwm shutdown and dead-band registers clear on resets, kept on wake
// - serial2 address/status/controls clear on resets, buffer undefined at power-on
// - external bus control clears implemented bits, one position reads zero
// - usart2 tx data clears on resets, usart1 tx data undefined at power-on
// - registers without forced state undefined at power-on, else unchanged
`timescale 1ns/1ps

module reg_init_bank
  import reg_init_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire reset_event_t reset_event,
  input  wire logic        high_priority_global_enable,
  input  wire logic        low_priority_global_enable,
  input  wire logic [7:0]  wake_cause,
  input  wire pc_t         pc_current,
  output pc_t              pc_load_value,
  output logic             pc_load,
  output pc_t              stack_top,
  output logic [sp_w-1:0]  stack_pointer_reg,
  output reset_class_t     reset_class
);

  // ------------------------------------------------------------
  // init table
  // ------------------------------------------------------------
  function automatic init_entry_t entry_of(input int unsigned i);
    init_entry_t e;
    e = e_undef;
    if (i == idx_ccp1_control || i == idx_ccp2_control || i == idx_ccp3_control)
      e = e_zero;
    else if (i == idx_comparator_control)
      e = '{v_cmp, 1'b1, v_cmp, 1'b0, v_zero, m_all};
    else if (i == idx_timer3_control)
      e = '{v_zero, 1'b0, v_zero, 1'b0, v_zero, m_all};
    else if (i == idx_usart1_tx_status || i == idx_usart2_tx_status)
      e = '{v_txsta, 1'b1, v_txsta, 1'b0, v_zero, m_all};
    else if (i == idx_usart1_rx_status || i == idx_usart2_rx_status)
      e = e_zero;                                            // bit 0 undefined, modelled as 0
    else if (i == idx_timer4_period)
      e = '{v_ones, 1'b1, v_ones, 1'b1, v_ones, m_all};
    else if (i == idx_priority1 || i == idx_priority3)
      e = e_ones;
    else if (i == idx_enable1 || i == idx_enable3 || i == idx_request1 || i == idx_request3)
      e = e_zero;
    else if (i == idx_timer4_counter)
      e = e_zero;
    else if (i == idx_timer4_control)
      e = '{v_zero, 1'b1, v_zero, 1'b0, v_zero, m_timer4_ctl};
    else if (i == idx_flash_write_ctrl)
      // no forced load on other resets: the error bit must survive them
      e = '{v_zero, 1'b0, v_zero, 1'b1, v_zero, m_flash};
    else if (i == idx_pwm1_auto_shutdown || i == idx_pwm1_dead_band ||
             i == idx_pwm2_auto_shutdown || i == idx_pwm2_dead_band ||
             i == idx_pwm3_auto_shutdown || i == idx_pwm3_dead_band)
      e = e_zero;
    else if (i == idx_serial2_address || i == idx_serial2_status)
      e = e_zero;
    else if (i == idx_external_bus_ctrl)
      e = '{v_zero, 1'b1, v_zero, 1'b0, v_zero, m_membus};
    else if (i == idx_usart2_tx_data || i == idx_usart1_baud)
      e = e_zero;
    return e;
  endfunction

  function automatic logic [11:0] reg_addr(input int unsigned i);
    return 12'(i * 4);
  endfunction

  function automatic reg_byte_t mask_of(input int unsigned i);
    init_entry_t e;
    e = entry_of(i);
    return e.mask;
  endfunction

  // ------------------------------------------------------------
  // reset class decode
  // ------------------------------------------------------------
  reset_class_t cls_nxt;
  always_comb begin
    // power wins over other, other over wake, so exactly one class per event
    if (reset_event.power)
      cls_nxt = cls_power;
    else if (reset_event.other)
      cls_nxt = cls_other;
    else if (reset_event.wake_wdt || reset_event.wake_irq)
      cls_nxt = cls_wake;
    else
      cls_nxt = cls_none;
  end

  // ------------------------------------------------------------
  // apb access decode
  // ------------------------------------------------------------
  logic access_w;
  logic wr_en;
  logic addr_hit;
  int unsigned hit_idx;
  logic ctl_hit;
  logic ctl_sel;

  assign access_w = psel && penable;
  assign wr_en    = access_w && pwrite;

  always_comb begin
    addr_hit = 1'b0;
    hit_idx  = 0;
    ctl_hit  = 1'b0;
    ctl_sel  = 1'b0;
    if (paddr == addr_serial2_ctl1) begin
      ctl_hit = 1'b1;
    end else if (paddr == addr_serial2_ctl2) begin
      ctl_hit = 1'b1;
      ctl_sel = 1'b1;
    end else begin
      for (int unsigned k = 0; k < num_regs; k++) begin
        if (paddr == reg_addr(k)) begin
          addr_hit = 1'b1;
          hit_idx  = k;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  reg_array_t regs_r;
  reg_array_t regs_nxt;
  reg_byte_t  ctl_r [num_ctl];
  reg_byte_t  ctl_nxt [num_ctl];
  logic       irq_wake_vec;

  assign irq_wake_vec = cls_nxt == cls_wake && reset_event.wake_irq &&
                        (high_priority_global_enable || low_priority_global_enable);

  generate
    for (genvar g = 0; g < num_regs; g++) begin : g_reg
      localparam init_entry_t ent = entry_of(g);
      always_comb begin
        regs_nxt[g] = regs_r[g];
        if (cls_nxt == cls_power)
          regs_nxt[g] = ent.power_val;
        else if (cls_nxt == cls_other && ent.other_load)
          regs_nxt[g] = ent.other_val;
        else if (cls_nxt == cls_other && g == idx_flash_write_ctrl)
          regs_nxt[g] = regs_r[g] & ~m_flash_clear;           // error bit kept
        else if (cls_nxt == cls_wake && ent.wake_load)
          regs_nxt[g] = (g == idx_flash_write_ctrl) ? (regs_r[g] & ~m_flash_clear) : ent.wake_val;
        else if (cls_nxt == cls_wake && reset_event.wake_irq &&
                 (g == idx_request1 || g == idx_request3))
          regs_nxt[g] = regs_r[g] | (g == idx_request1 ? wake_cause : v_zero);
        else if (cls_nxt == cls_none && wr_en && addr_hit && hit_idx == g)
          regs_nxt[g] = pwdata[7:0] & ent.mask;
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          regs_r[g] <= ent.power_val;
        else
          regs_r[g] <= regs_nxt[g];
      end
    end
    for (genvar c = 0; c < num_ctl; c++) begin : g_ctl
      always_comb begin
        ctl_nxt[c] = ctl_r[c];
        if (cls_nxt == cls_power || cls_nxt == cls_other)
          ctl_nxt[c] = v_zero;
        else if (cls_nxt == cls_none && wr_en && ctl_hit && ctl_sel == 1'(c))
          ctl_nxt[c] = pwdata[7:0];
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          ctl_r[c] <= v_zero;
        else
          ctl_r[c] <= ctl_nxt[c];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // pc, stack and bus answer
  // ------------------------------------------------------------
  pc_t               pc_load_value_nxt;
  logic              pc_load_nxt;
  pc_t               stack_top_nxt;
  logic [sp_w-1:0]   sp_nxt;
  logic [31:0]       prdata_nxt;
  logic              pready_nxt;
  logic              pslverr_nxt;

  always_comb begin
    pc_load_nxt       = 1'b0;
    pc_load_value_nxt = pc_load_value;
    stack_top_nxt     = stack_top;
    sp_nxt            = stack_pointer_reg;
    if (cls_nxt == cls_power || cls_nxt == cls_other) begin
      pc_load_nxt       = 1'b1;
      pc_load_value_nxt = vec_reset;
      stack_top_nxt     = vec_reset;
      sp_nxt            = '0;
    end else if (irq_wake_vec) begin
      stack_top_nxt     = pc_current;
      sp_nxt            = stack_pointer_reg + 5'(1);
      pc_load_nxt       = 1'b1;
      pc_load_value_nxt = reset_event.irq_high ? vec_high : vec_low;
    end else if (cls_nxt == cls_wake) begin
      pc_load_nxt       = 1'b1;
      pc_load_value_nxt = pc_t'(pc_current + pc_step);
    end
    // one-cycle answer: pready high during every access phase
    pready_nxt  = psel && !penable;
    pslverr_nxt = psel && !penable && !(addr_hit || ctl_hit);
    prdata_nxt  = '0;
    if (psel && !penable && !pwrite) begin
      if (ctl_hit)
        prdata_nxt = {24'h000000, ctl_r[ctl_sel]};
      else if (addr_hit && hit_idx != idx_usart2_tx_data)
        prdata_nxt = {24'h000000, regs_r[hit_idx] & mask_of(hit_idx)};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_load           <= 1'b0;
      pc_load_value     <= vec_reset;
      stack_top         <= vec_reset;
      stack_pointer_reg <= '0;
      reset_class       <= cls_none;
      prdata            <= '0;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
    end else begin
      pc_load           <= pc_load_nxt;
      pc_load_value     <= pc_load_value_nxt;
      stack_top         <= stack_top_nxt;
      stack_pointer_reg <= sp_nxt;
      reset_class       <= cls_nxt;
      prdata            <= prdata_nxt;
      pready            <= pready_nxt;
      pslverr           <= pslverr_nxt;
    end
  end

endmodule

// *** reg_init_pkg.sv ***
// package for the peripheral register bank with reset-class initialization
// assumes a 32-bit apb master and one 40 MHz core clock
package reg_init_pkg;

  // ------------------------------------------------------------
  // reset classes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    cls_none,
    cls_power,
    cls_other,
    cls_wake
  } reset_class_t;

  // ------------------------------------------------------------
  // register index and storage
  // ------------------------------------------------------------
  localparam int unsigned num_regs = 40;
  typedef logic [7:0] reg_byte_t;
  typedef reg_byte_t [num_regs-1:0] reg_array_t;

  localparam int unsigned idx_ccp1_data_low      = 0;
  localparam int unsigned idx_ccp1_data_high     = 1;
  localparam int unsigned idx_ccp1_control       = 2;
  localparam int unsigned idx_ccp2_data_low      = 3;
  localparam int unsigned idx_ccp2_data_high     = 4;
  localparam int unsigned idx_ccp2_control       = 5;
  localparam int unsigned idx_ccp3_data_low      = 6;
  localparam int unsigned idx_ccp3_data_high     = 7;
  localparam int unsigned idx_ccp3_control       = 8;
  localparam int unsigned idx_pwm1_auto_shutdown = 9;
  localparam int unsigned idx_comparator_control = 10;
  localparam int unsigned idx_timer3_count_low   = 11;
  localparam int unsigned idx_timer3_count_high  = 12;
  localparam int unsigned idx_timer3_control     = 13;
  localparam int unsigned idx_usart1_baud        = 14;
  localparam int unsigned idx_usart1_tx_data     = 15;
  localparam int unsigned idx_usart1_tx_status   = 16;
  localparam int unsigned idx_usart1_rx_status   = 17;
  localparam int unsigned idx_flash_write_ctrl   = 18;
  localparam int unsigned idx_priority3          = 19;
  localparam int unsigned idx_request3           = 20;
  localparam int unsigned idx_enable3            = 21;
  localparam int unsigned idx_priority1          = 22;
  localparam int unsigned idx_request1           = 23;
  localparam int unsigned idx_enable1            = 24;
  localparam int unsigned idx_external_bus_ctrl  = 25;
  localparam int unsigned idx_pwm1_dead_band     = 26;
  localparam int unsigned idx_timer4_counter     = 27;
  localparam int unsigned idx_timer4_period      = 28;
  localparam int unsigned idx_timer4_control     = 29;
  localparam int unsigned idx_usart2_tx_data     = 30;
  localparam int unsigned idx_usart2_tx_status   = 31;
  localparam int unsigned idx_usart2_rx_status   = 32;
  localparam int unsigned idx_pwm3_auto_shutdown = 33;
  localparam int unsigned idx_pwm3_dead_band     = 34;
  localparam int unsigned idx_pwm2_auto_shutdown = 35;
  localparam int unsigned idx_pwm2_dead_band     = 36;
  localparam int unsigned idx_serial2_buffer     = 37;
  localparam int unsigned idx_serial2_address    = 38;
  localparam int unsigned idx_serial2_status     = 39;
  // serial2 control 1/2 are grouped with status: see ctl indices below
  localparam int unsigned num_ctl = 2;
  localparam logic [11:0] addr_serial2_ctl1 = 12'h0a0;
  localparam logic [11:0] addr_serial2_ctl2 = 12'h0a4;

  // ------------------------------------------------------------
  // per-register init behaviour
  // ------------------------------------------------------------
  // power_val: value after power-on/brown-out; other_load: forced on other resets
  // wake_load: forced on wake-up; mask: implemented bits
  typedef struct packed {
    reg_byte_t power_val;
    logic      other_load;
    reg_byte_t other_val;
    logic      wake_load;
    reg_byte_t wake_val;
    reg_byte_t mask;
  } init_entry_t;

  localparam reg_byte_t v_zero  = 8'h00;
  localparam reg_byte_t v_ones  = 8'hff;
  localparam reg_byte_t v_cmp   = 8'h07;
  localparam reg_byte_t v_txsta = 8'h02;
  localparam reg_byte_t m_all   = 8'hff;
  localparam reg_byte_t m_timer4_ctl = 8'h7f;
  localparam reg_byte_t m_flash = 8'h1e;
  localparam reg_byte_t m_membus = 8'hbf;
  localparam reg_byte_t m_flash_clear = 8'h16;
  localparam int unsigned flash_err_bit = 3;

  // undefined contents modelled as zero on power-on
  localparam init_entry_t e_undef  = '{v_zero, 1'b0, v_zero, 1'b0, v_zero, m_all};
  localparam init_entry_t e_zero   = '{v_zero, 1'b1, v_zero, 1'b0, v_zero, m_all};
  localparam init_entry_t e_ones   = '{v_ones, 1'b1, v_ones, 1'b0, v_zero, m_all};

  // ------------------------------------------------------------
  // program counter and vectors
  // ------------------------------------------------------------
  localparam int unsigned pc_w = 21;
  localparam int unsigned sp_w = 5;
  typedef logic [pc_w-1:0] pc_t;
  localparam pc_t vec_reset = 21'h000000;
  localparam pc_t vec_high  = 21'h000008;
  localparam pc_t vec_low   = 21'h000018;
  localparam pc_t pc_step   = 21'h000002;

  typedef struct packed {
    logic power;
    logic other;
    logic wake_wdt;
    logic wake_irq;
    logic irq_high;
  } reset_event_t;

endpackage

// *** reg_init_props.sv ***
// checker for the register bank: apb answers, reset classes, wake vectoring
// assumes one clock and an asynchronous active-low reset on the bound bank
`timescale 1ns/1ps

module reg_init_props
  import reg_init_pkg::*;
(
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire reset_event_t    reset_event,
  input wire logic            high_priority_global_enable,
  input wire logic            low_priority_global_enable,
  input wire pc_t             pc_current,
  input wire pc_t             pc_load_value,
  input wire logic            pc_load,
  input wire pc_t             stack_top,
  input wire logic [sp_w-1:0] stack_pointer_reg,
  input wire reset_class_t    reset_class
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic any_ev;
  logic gie;
  assign any_ev = reset_event.power | reset_event.other | reset_event.wake_wdt | reset_event.wake_irq;
  assign gie    = high_priority_global_enable | low_priority_global_enable;

  // --------------------------------------------------------
  // wake sequences
  // --------------------------------------------------------
  sequence irq_wake_s;
    reset_event.wake_irq && !reset_event.power && !reset_event.other && gie;
  endsequence
  sequence pushed_s;
    pc_load && stack_top == $past(pc_current) && stack_pointer_reg == $past(stack_pointer_reg) + 1'b1;
  endsequence

  power_class_a: assert property (reset_event.power |=> reset_class == cls_power && pc_load && pc_load_value == vec_reset)
    else $error("power event not decoded");
  other_class_a: assert property (reset_event.other && !reset_event.power |=> reset_class == cls_other && pc_load_value == vec_reset)
    else $error("other reset not decoded");
  wake_class_a: assert property ((reset_event.wake_wdt || reset_event.wake_irq) && !reset_event.power && !reset_event.other |=> reset_class == cls_wake)
    else $error("wake event not decoded");
  quiet_class_a: assert property (!any_ev |=> reset_class == cls_none && !pc_load)
    else $error("class or pc load without event");
  stack_push_a: assert property (irq_wake_s |=> pushed_s)
    else $error("stack not pushed on interrupt wake");
  irq_vector_a: assert property (irq_wake_s |=> pc_load_value == ($past(reset_event.irq_high) ? vec_high : vec_low))
    else $error("wrong interrupt vector");
  wdt_resume_a: assert property (reset_event.wake_wdt && !reset_event.wake_irq && !reset_event.power && !reset_event.other
    |=> pc_load && pc_load_value == $past(pc_current) + pc_step && $stable(stack_pointer_reg))
    else $error("watchdog wake did not resume at next instruction");
  unmapped_err_a: assert property (psel && !penable && paddr >= 12'ha8 |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0 && $past(psel))
    else $error("read data upper bits not zero");
endmodule

bind reg_init_bank reg_init_props chk_u (.clk, .rst_n, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .reset_event,
  .high_priority_global_enable, .low_priority_global_enable, .pc_current, .pc_load_value, .pc_load, .stack_top,
  .stack_pointer_reg, .reset_class);

// *** tb_top.sv ***
// self-checking bench for the register bank: reset classes, apb access, wake vectoring
// assumes the bank answers each apb access in the cycle after setup
`timescale 1ns/1ps

module tb_top import reg_init_pkg::*; ;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  reset_event_t    reset_event = '0;
  logic            high_priority_global_enable = 1'b0;
  logic            low_priority_global_enable = 1'b0;
  logic [7:0]      wake_cause = 8'h00;
  pc_t             pc_current = 21'h000000;
  pc_t             pc_load_value;
  logic            pc_load;
  pc_t             stack_top;
  logic [sp_w-1:0] stack_pointer_reg;
  reset_class_t    reset_class;
  int              errors = 0;
  int              n_checks = 0;
  int              cycles = 0;
  logic [31:0]     rd;
  logic            err;
  logic [sp_w-1:0] sp_exp;
  // one letter per register index; 40 and 41 are the serial2 controls
  string           cats = "UUZUUZUUZZCUUTZUXRFOZZOZZMZZPNWXRZZZZUZZZZ";
  reset_event_t    ev_tab [3] = '{5'b10000, 5'b01000, 5'b00100};
  reset_class_t    cls_tab [3] = '{cls_power, cls_other, cls_wake};
  pc_t             vec_tab [3] = '{21'h000008, 21'h000018, 21'h012346};

  reg_init_bank dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .reset_event, .high_priority_global_enable, .low_priority_global_enable, .wake_cause, .pc_current,
    .pc_load_value, .pc_load, .stack_top, .stack_pointer_reg, .reset_class);

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end

  // --------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the cycle ceiling ends a wait that never sees pready
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic fire(input reset_event_t e, input reset_class_t cls);
    @(posedge clk);
    reset_event <= e;
    @(posedge clk);
    reset_event <= '0;
    #1;
    chk("reset_class", 32'(cls), 32'(reset_class));
  endtask

  // undefined contents read as zero; c picks mask, reset value and forced bits
  function automatic reg_byte_t expect_of(input byte c, input int cls, input reg_byte_t w);
    reg_byte_t m;
    reg_byte_t pv;
    reg_byte_t f;
    m  = (c == "M") ? 8'hbf : (c == "N") ? 8'h7f : (c == "F") ? 8'h1e : (c == "W") ? 8'h00 : 8'hff;
    pv = (c == "O" || c == "P") ? 8'hff : (c == "C") ? 8'h07 : (c == "X") ? 8'h02 : 8'h00;
    f  = (cls == 0 || c == "P") ? 8'hff : (c == "F") ? 8'h16 : (cls == 1 && c != "U" && c != "T") ? 8'hff : 8'h00;
    return (w & m & ~f) | (pv & f);
  endfunction

  // --------------------------------------------------------
  // main sequence
  // --------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 42; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk($sformatf("reset reg %0d", i), 32'(expect_of(cats[i], 0, 8'h00)), rd);
      chk($sformatf("mapped err %0d", i), 32'h0, {31'h0, err});
    end
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 42; i++) apb(1'b1, 12'(i * 4), 32'hffffffde);
      fire(ev_tab[k], cls_tab[k]);
      for (int i = 0; i < 42; i++) begin
        apb(1'b0, 12'(i * 4), 32'h0);
        chk($sformatf("class %0d reg %0d", k, i), 32'(expect_of(cats[i], k, 8'hde)), rd);
      end
    end
    apb(1'b1, 12'hffc, 32'h55);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    // write in the same cycle as a reset event must lose
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= 12'(idx_comparator_control * 4);
    pwdata <= 32'h0;
    @(posedge clk);
    penable <= 1'b1;
    reset_event <= 5'b01000;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    reset_event <= '0;
    apb(1'b0, 12'(idx_comparator_control * 4), 32'h0);
    chk("cmp_after_clash", 32'h07, rd);
    // the other reset above already cleared request1; clear it again so the cause flag must come from the wake
    apb(1'b1, 12'(idx_request1 * 4), 32'h0);
    pc_current <= 21'h012344;
    wake_cause <= 8'h04;
    for (int k = 0; k < 3; k++) begin
      high_priority_global_enable <= (k == 0);
      low_priority_global_enable <= (k == 1);
      sp_exp = stack_pointer_reg + sp_w'(k < 2);
      fire({4'b0001, k == 0}, cls_wake);
      chk("pc_load", 32'h1, {31'h0, pc_load});
      chk("pc_value", 32'(vec_tab[k]), 32'(pc_load_value));
      chk("stack_pointer", 32'(sp_exp), 32'(stack_pointer_reg));
      if (k < 2) chk("stack_top", 32'h012344, 32'(stack_top));
    end
    apb(1'b0, 12'(idx_request1 * 4), 32'h0);
    chk("request_flag", 32'h04, rd & 32'h04);
    wrap_up();
  end
endmodule
